// file: src/spwe_defines.vh
// Constants for the secondary 64-bit extension block
`ifndef SPWE_DEFINES_VH
`define SPWE_DEFINES_VH

// Clock
`define SPWE_CLK_PERIOD_NS     10

// Lane widths
`define SPWE_AD_W              32
`define SPWE_CBE_W             4

// Device select wait before master abort, in clocks after frame start
`define SPWE_DEVSEL_WAIT_CYC   3'h5
`define SPWE_CNT_W             3

// Reset values
`define SPWE_RST_AD            32'h00000000
`define SPWE_RST_CBE           4'h0
`define SPWE_RST_NEG_N         1'b1
`define SPWE_RST_OE            1'b0
`define SPWE_RST_PAR           1'b0
`define SPWE_RST_CNT           3'h0
`define SPWE_CNT_ONE           3'h1

`endif

// file: src/spwe_par_check.v
// Even parity checker for received upper lanes, one clock behind the data
`timescale 1ns/1ps
`include "spwe_defines.vh"

module spwe_par_check #(
	parameter W = 36
) (
	// Clock and reset
	input  wire         clk,
	input  wire         rst,
	// Captured lanes and their strobe
	input  wire         strobe,
	input  wire [W-1:0] lanes,
	// Parity pin as seen one clock later
	input  wire         par_in,
	// Mismatch pulse
	output wire         par_err
);

	reg expect_reg;
	reg armed_reg;
	reg err_reg;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			expect_reg <= `SPWE_RST_PAR;
			armed_reg  <= 1'b0;
			err_reg    <= 1'b0;
		end else begin
			expect_reg <= ^lanes;
			armed_reg  <= strobe;
			// Parity bit makes the 37-bit total even
			err_reg    <= armed_reg & (expect_reg != par_in);
		end
	end

	assign par_err = err_reg;

endmodule

// file: src/spwe_ext.v
// Upper-lane extension of the secondary bus port: 64-bit lanes and control
`timescale 1ns/1ps
`include "spwe_defines.vh"

// Summary of operation
// - DAC address phase with wide request puts upper address on upper lanes.
// - Upper data lanes carry data once wide request is latched, unless the target selects without ack.
// - DAC address phase with wide request puts bus command on upper CBE.
// - In wide data phases upper CBE flag valid upper byte lanes.
// - Wide request input is ignored while reset is asserted.
// - As master, request wide for wide forwarded traffic or forced option.
// - Wide acknowledge moves exactly with our device select drive when a wide request was seen.
// - Wide acknowledge is driven high one clock before release.
// - Upper parity is even over upper AD and upper CBE lanes.
// - Upper parity is valid one clock after each wide address phase.
// - As master, abort if no device select within five clocks of frame.
module spwe_ext (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Option strap
	input  wire        forced_wide_option,
	// Master side, from the 32-bit port logic
	input  wire        mst_own,
	input  wire        mst_frame_drive,
	input  wire        mst_wide_txn,
	input  wire        mst_addr_phase,
	input  wire        mst_dac,
	input  wire [31:0] mst_addr_hi,
	input  wire [3:0]  mst_cmd,
	input  wire        mst_data_phase,
	input  wire        mst_write,
	input  wire [31:0] mst_data_hi,
	input  wire [3:0]  mst_be_hi,
	input  wire        mst_xfer,
	// Target side, from the 32-bit port logic
	input  wire        tgt_devsel_drive,
	input  wire        tgt_data_phase,
	input  wire        tgt_read,
	input  wire [31:0] tgt_data_hi,
	input  wire        tgt_xfer,
	// Secondary bus, lower control lines observed
	input  wire        sec_frame_n_i,
	input  wire        sec_target_select_n_i,
	// Secondary bus, upper address and data
	input  wire [31:0] sec_ad_hi_i,
	output wire [31:0] sec_ad_hi_o,
	output wire        sec_ad_hi_oe,
	// Secondary bus, upper command and byte enables
	input  wire [3:0]  sec_upper_cmd_byte_en_i,
	output wire [3:0]  sec_upper_cmd_byte_en_o,
	output wire        sec_upper_cmd_byte_en_oe,
	// Secondary bus, wide request
	input  wire        sec_wide_request_n_i,
	output wire        sec_wide_request_n_o,
	output wire        sec_wide_request_n_oe,
	// Secondary bus, wide acknowledge
	input  wire        sec_wide_ack_n_i,
	output wire        sec_wide_ack_n_o,
	output wire        sec_wide_ack_n_oe,
	// Secondary bus, upper parity
	input  wire        sec_upper_parity_i,
	output wire        sec_upper_parity_o,
	output wire        sec_upper_parity_oe,
	// Status to the 32-bit port logic
	output wire        wide_active,
	output wire        master_abort,
	output wire [31:0] rx_data_hi,
	output wire [3:0]  rx_be_hi,
	output wire        rx_valid,
	output wire        rx_par_err
);

	reg  [31:0] ad_reg;
	reg  [31:0] ad_next;
	reg         ad_oe_reg;
	reg         ad_oe_next;
	reg  [3:0]  cbe_reg;
	reg  [3:0]  cbe_next;
	reg         cbe_oe_reg;
	reg         cbe_oe_next;
	reg         req_n_reg;
	reg         req_oe_reg;
	reg         ack_n_reg;
	reg         ack_oe_reg;
	reg         par_reg;
	reg         par_oe_reg;
	reg         frame_q_reg;
	reg         req_lat_reg;
	reg         devsel_seen_reg;
	reg         mst_wide_reg;
	reg         req_seen_reg;
	reg         wide_act_reg;
	reg         abort_reg;
	reg         abort_run_reg;
	reg  [2:0]  abort_cnt_reg;
	reg  [31:0] rx_data_reg;
	reg  [3:0]  rx_be_reg;
	reg         rx_valid_reg;

	wire        frame_start;
	wire        wide_want;
	wire        devsel_now;
	wire        devsel_any;
	wire        wide_any;
	wire        mst_ok;
	wire        tgt_wide;
	wire        rx_take;
	wire [31:0] ad_bus;
	wire [3:0]  cbe_bus;

	assign frame_start = ~sec_frame_n_i & frame_q_reg;
	assign wide_want   = mst_wide_txn | forced_wide_option;
	assign devsel_now  = ~sec_target_select_n_i;
	// Ack is only meaningful together with device select
	assign devsel_any  = devsel_seen_reg | devsel_now;
	assign wide_any    = mst_wide_reg | (devsel_now & ~sec_wide_ack_n_i);
	// Before the target answers, a wide request keeps upper lanes in use
	assign mst_ok      = req_lat_reg & (~devsel_any | wide_any);
	assign tgt_wide    = tgt_devsel_drive & req_seen_reg;
	assign rx_take     = (mst_own & mst_xfer & ~mst_write & mst_ok) |
	                     (tgt_xfer & ~tgt_read & tgt_wide);
	// Lanes as they stand on the bus this cycle
	assign ad_bus      = ad_oe_reg ? ad_reg : sec_ad_hi_i;
	assign cbe_bus     = cbe_oe_reg ? cbe_reg : sec_upper_cmd_byte_en_i;

	// Next drive of the upper lanes
	always @* begin
		ad_next     = ad_reg;
		ad_oe_next  = 1'b0;
		cbe_next    = cbe_reg;
		cbe_oe_next = 1'b0;
		if (mst_own & mst_addr_phase & wide_want) begin
			// Both DAC phases carry the high address half
			ad_next     = mst_addr_hi;
			ad_oe_next  = 1'b1;
			cbe_next    = mst_cmd;
			cbe_oe_next = 1'b1;
		end else if (mst_own & mst_data_phase & mst_ok) begin
			cbe_next    = mst_be_hi;
			cbe_oe_next = 1'b1;
			if (mst_write) begin
				ad_next    = mst_data_hi;
				ad_oe_next = 1'b1;
			end
		end else if (tgt_data_phase & tgt_read & tgt_wide) begin
			ad_next    = tgt_data_hi;
			ad_oe_next = 1'b1;
		end
	end

	// Lane drivers and parity
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ad_reg     <= `SPWE_RST_AD;
			ad_oe_reg  <= `SPWE_RST_OE;
			cbe_reg    <= `SPWE_RST_CBE;
			cbe_oe_reg <= `SPWE_RST_OE;
			par_reg    <= `SPWE_RST_PAR;
			par_oe_reg <= `SPWE_RST_OE;
		end else begin
			ad_reg     <= ad_next;
			ad_oe_reg  <= ad_oe_next;
			cbe_reg    <= cbe_next;
			cbe_oe_reg <= cbe_oe_next;
			// Whoever drove the upper AD lanes drives parity a clock later
			par_reg    <= ^{ad_bus, cbe_bus};
			par_oe_reg <= ad_oe_reg;
		end
	end

	// Wide request as master
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			req_n_reg   <= `SPWE_RST_NEG_N;
			req_oe_reg  <= `SPWE_RST_OE;
			req_lat_reg <= 1'b0;
		end else begin
			// Follows the frame drive of the 32-bit logic
			req_n_reg  <= ~(mst_own & mst_frame_drive & wide_want);
			// Driven high for one clock after the last low
			req_oe_reg <= mst_own | (req_oe_reg & ~req_n_reg);
			if (mst_own & mst_addr_phase)
				req_lat_reg <= wide_want;
			else if (~mst_own)
				req_lat_reg <= 1'b0;
		end
	end

	// Master view of the target answer
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			devsel_seen_reg <= 1'b0;
			mst_wide_reg    <= 1'b0;
		end else if (~mst_own | (mst_addr_phase & ~mst_dac)) begin
			devsel_seen_reg <= 1'b0;
			mst_wide_reg    <= 1'b0;
		end else if (devsel_now & ~devsel_seen_reg) begin
			devsel_seen_reg <= 1'b1;
			mst_wide_reg    <= req_lat_reg & ~sec_wide_ack_n_i;
		end
	end

	// Master abort on missing device select
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_q_reg   <= 1'b1;
			abort_run_reg <= 1'b0;
			abort_cnt_reg <= `SPWE_RST_CNT;
			abort_reg     <= 1'b0;
		end else begin
			frame_q_reg <= sec_frame_n_i;
			abort_reg   <= 1'b0;
			if (frame_start & mst_own) begin
				abort_run_reg <= 1'b1;
				abort_cnt_reg <= `SPWE_CNT_ONE;
			end else if (abort_run_reg) begin
				if (devsel_now | ~mst_own) begin
					abort_run_reg <= 1'b0;
				end else if (abort_cnt_reg == `SPWE_DEVSEL_WAIT_CYC) begin
					abort_run_reg <= 1'b0;
					abort_reg     <= 1'b1;
				end else begin
					abort_cnt_reg <= abort_cnt_reg + `SPWE_CNT_ONE;
				end
			end
		end
	end

	// Target: sample wide request at address phase, answer with ack
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			// Nothing on the request pin is seen while reset holds
			req_seen_reg <= 1'b0;
			ack_n_reg    <= `SPWE_RST_NEG_N;
			ack_oe_reg   <= `SPWE_RST_OE;
		end else begin
			// Initiator side asserts its request with frame
			if (frame_start & ~mst_own)
				req_seen_reg <= ~sec_wide_request_n_i;
			else if (~sec_frame_n_i | tgt_devsel_drive)
				req_seen_reg <= req_seen_reg;
			else
				req_seen_reg <= 1'b0;
			// Same source as the device select drive, same edge
			ack_n_reg  <= ~(tgt_devsel_drive & req_seen_reg);
			ack_oe_reg <= tgt_devsel_drive | (ack_oe_reg & ~ack_n_reg);
		end
	end

	// Received upper data and status
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_data_reg  <= `SPWE_RST_AD;
			rx_be_reg    <= `SPWE_RST_CBE;
			rx_valid_reg <= 1'b0;
			wide_act_reg <= 1'b0;
		end else begin
			rx_valid_reg <= rx_take;
			if (rx_take) begin
				rx_data_reg <= sec_ad_hi_i;
				rx_be_reg   <= cbe_bus;
			end
			wide_act_reg <= (mst_own & req_lat_reg & devsel_any & wide_any) |
			                tgt_wide;
		end
	end

	spwe_par_check #(
		.W (36)
	) u_par_check (
		.clk     (clk),
		.rst     (rst),
		.strobe  (rx_take),
		.lanes   ({sec_ad_hi_i, cbe_bus}),
		.par_in  (sec_upper_parity_i),
		.par_err (rx_par_err)
	);

	assign sec_ad_hi_o              = ad_reg;
	assign sec_ad_hi_oe             = ad_oe_reg;
	assign sec_upper_cmd_byte_en_o  = cbe_reg;
	assign sec_upper_cmd_byte_en_oe = cbe_oe_reg;
	assign sec_wide_request_n_o     = req_n_reg;
	assign sec_wide_request_n_oe    = req_oe_reg;
	assign sec_wide_ack_n_o         = ack_n_reg;
	assign sec_wide_ack_n_oe        = ack_oe_reg;
	assign sec_upper_parity_o       = par_reg;
	assign sec_upper_parity_oe      = par_oe_reg;
	assign wide_active              = wide_act_reg;
	assign master_abort             = abort_reg;
	assign rx_data_hi               = rx_data_reg;
	assign rx_be_hi                 = rx_be_reg;
	assign rx_valid                 = rx_valid_reg;

endmodule

// file: verif/spwe_ext_asserts.sv
// Port assertions for the upper-lane extension
`timescale 1ns/1ps
module spwe_ext_asserts (
	// Clock, reset and control inputs
	input wire        clk, rst, forced_wide_option, mst_own,
	input wire        mst_frame_drive, mst_wide_txn, mst_addr_phase, mst_dac,
	input wire [31:0] mst_addr_hi,
	input wire [3:0]  mst_cmd,
	input wire        tgt_devsel_drive, sec_frame_n_i, sec_target_select_n_i,
	// Driven lanes and status
	input wire [31:0] sec_ad_hi_o,
	input wire [3:0]  sec_upper_cmd_byte_en_o,
	input wire        sec_ad_hi_oe, sec_upper_cmd_byte_en_oe,
	input wire        sec_wide_request_n_o, sec_wide_ack_n_o,
	input wire        sec_wide_ack_n_oe, sec_upper_parity_o,
	input wire        sec_upper_parity_oe, master_abort, rx_valid
);
	wire want;
	assign want = mst_wide_txn | forced_wide_option;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	req_on_a: assert property (
		mst_own && mst_frame_drive && want |=> !sec_wide_request_n_o)
		else $error("wide request missing");
	req_off_a: assert property (
		!(mst_own && mst_frame_drive && want) |=> sec_wide_request_n_o)
		else $error("wide request unasked");
	ack_dev_a: assert property (
		!sec_wide_ack_n_o |-> $past(tgt_devsel_drive))
		else $error("wide ack off select timing");
	ack_high_a: assert property (
		$fell(sec_wide_ack_n_oe) |-> $past(sec_wide_ack_n_o))
		else $error("wide ack released low");
	addr_hi_a: assert property (
		mst_own && mst_addr_phase && mst_dac && want |=>
		sec_ad_hi_oe && sec_ad_hi_o == $past(mst_addr_hi))
		else $error("upper address wrong");
	cmd_hi_a: assert property (
		mst_own && mst_addr_phase && mst_dac && want |=>
		sec_upper_cmd_byte_en_oe &&
		sec_upper_cmd_byte_en_o == $past(mst_cmd))
		else $error("upper command wrong");
	par_even_a: assert property (
		sec_ad_hi_oe && sec_upper_cmd_byte_en_oe |=> sec_upper_parity_oe &&
		sec_upper_parity_o == ^{$past(sec_ad_hi_o),
		$past(sec_upper_cmd_byte_en_o)})
		else $error("upper parity wrong");
	abort_a: assert property (
		$fell(sec_frame_n_i) && mst_own ##1
		(sec_target_select_n_i && mst_own)[*5] |=> master_abort)
		else $error("master abort missing");
	abort_c: cover property (master_abort);
	ack_c: cover property (!sec_wide_ack_n_o);
	rx_c: cover property (rx_valid);
endmodule

bind spwe_ext spwe_ext_asserts i_chk (.*);

// file: verif/spwe_bus_agent.sv
// Far-side agent: responding target and wide initiator
`timescale 1ns/1ps
module spwe_bus_agent (
	// Clock and scenario controls
	input  wire        clk, acc, ini_req, drv, bad,
	input  wire [2:0]  dly,
	input  wire [31:0] wdata,
	// Bridge drives
	input  wire        sec_frame_n_i, sec_ad_hi_oe, sec_upper_cmd_byte_en_oe,
	input  wire [31:0] sec_ad_hi_o,
	input  wire [3:0]  sec_upper_cmd_byte_en_o,
	input  wire        sec_wide_request_n_o, sec_wide_request_n_oe,
	input  wire        sec_wide_ack_n_o, sec_wide_ack_n_oe,
	input  wire        sec_upper_parity_o, sec_upper_parity_oe,
	// Resolved bus levels
	output wire        sec_target_select_n_i, sec_wide_request_n_i,
	output wire        sec_wide_ack_n_i, sec_upper_parity_i,
	output wire [31:0] sec_ad_hi_i,
	output wire [3:0]  sec_upper_cmd_byte_en_i
);
	reg [2:0]  cnt = 3'h0;
	reg        fq = 1'h1, sel = 1'h0, wide = 1'h0, pd = 1'h0;
	reg        mp = 1'h0, pq = 1'h0;
	reg [31:0] aq = 32'h0;
	reg [3:0]  cq = 4'h0;
	// Pulled-up lines go high when nobody drives them
	assign sec_target_select_n_i = !sel;
	assign sec_wide_request_n_i = sec_wide_request_n_oe ?
		sec_wide_request_n_o : !ini_req;
	assign sec_wide_ack_n_i = sec_wide_ack_n_oe ? sec_wide_ack_n_o :
		!(sel && wide);
	// Released lanes flip each cycle rather than hold
	assign sec_ad_hi_i = sec_ad_hi_oe ? sec_ad_hi_o : drv ? wdata : ~aq;
	assign sec_upper_cmd_byte_en_i = sec_upper_cmd_byte_en_oe ?
		sec_upper_cmd_byte_en_o : drv ? 4'h0 : ~cq;
	assign sec_upper_parity_i = sec_upper_parity_oe ? sec_upper_parity_o :
		pd ? mp : ~pq;
	always @(posedge clk) begin
		fq <= sec_frame_n_i;
		aq <= sec_ad_hi_i;
		cq <= sec_upper_cmd_byte_en_i;
		pq <= sec_upper_parity_i;
		pd <= drv;
		mp <= ^wdata ^ bad;
		if (sec_frame_n_i)
			cnt <= 3'h0;
		else if (fq) begin
			cnt <= 3'h1;
			wide <= acc && !sec_wide_request_n_i;
		end else if (cnt != 3'h0)
			cnt <= cnt + 3'h1;
		sel <= (dly != 3'h0 && cnt == dly) || (sel && !fq);
	end
endmodule

// file: verif/test_spwe_ext.sv
// Self-checking bench for the upper-lane extension
`timescale 1ns/1ps
module test_spwe_ext;
	reg         clk = 1'h0, rst = 1'h1, forced_wide_option = 1'h0;
	reg         mst_own = 1'h0, mst_frame_drive = 1'h0, mst_wide_txn = 1'h0;
	reg         mst_addr_phase = 1'h0, mst_dac = 1'h1, mst_data_phase = 1'h0;
	reg         mst_write = 1'h1, mst_xfer = 1'h0, tgt_devsel_drive = 1'h0;
	reg         tgt_data_phase = 1'h0, tgt_read = 1'h0, tgt_xfer = 1'h0;
	reg         sec_frame_n_i = 1'h1, acc = 1'h1, ini_req = 1'h1;
	reg         drv = 1'h0, bad = 1'h0;
	reg  [2:0]  dly = 3'h1;
	reg  [3:0]  mst_cmd = 4'hd, mst_be_hi = 4'h3;
	reg  [31:0] mst_addr_hi = 32'h9abc0123, mst_data_hi = 32'h13570ace;
	reg  [31:0] tgt_data_hi = 32'h0, wdata = 32'hc3a50f96;
	integer     n_errors = 0, n_compared = 0;
	wire [31:0] sec_ad_hi_i, sec_ad_hi_o, rx_data_hi;
	wire [3:0]  sec_upper_cmd_byte_en_i, sec_upper_cmd_byte_en_o, rx_be_hi;
	wire        sec_target_select_n_i, sec_ad_hi_oe, sec_upper_cmd_byte_en_oe;
	wire        sec_wide_request_n_i, sec_wide_request_n_o;
	wire        sec_wide_request_n_oe, sec_wide_ack_n_i, sec_wide_ack_n_o;
	wire        sec_wide_ack_n_oe, sec_upper_parity_i, sec_upper_parity_o;
	wire        sec_upper_parity_oe, wide_active, master_abort;
	wire        rx_valid, rx_par_err;

	spwe_ext i_dut (.*);
	spwe_bus_agent i_agent (.*);

	initial forever #5 clk = ~clk;
	initial begin
		#10000;
		n_errors = n_errors + 1;
		end_sim;
	end

	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("ERROR %0t: got %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task end_sim;
		begin
			if (n_errors == 0 && n_compared > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask

	task t_reset;
		begin
			repeat (8) begin
				@(negedge clk);
				sec_frame_n_i = ~sec_frame_n_i;
			end
			chk(sec_wide_request_n_o, 1'h1);
			chk(sec_wide_ack_n_oe, 1'h0);
			rst = 1'h0;
			ini_req = 1'h0;
			cyc(2);
			chk(wide_active, 1'h0);
		end
	endtask
	task t_master(input w, input f);
		begin
			mst_wide_txn = w;
			forced_wide_option = f;
			mst_own = 1'h1;
			mst_frame_drive = 1'h1;
			mst_addr_phase = 1'h1;
			cyc(1);
			sec_frame_n_i = 1'h0;
			mst_addr_phase = 1'h0;
			mst_data_phase = 1'h1;
			chk(sec_wide_request_n_o, !(w | f));
			chk(sec_ad_hi_oe, w | f);
			chk(sec_upper_cmd_byte_en_oe, w | f);
			if (w | f) begin
				chk(sec_ad_hi_o, mst_addr_hi);
				chk(sec_upper_cmd_byte_en_o, mst_cmd);
			end
			cyc(1);
			chk(sec_upper_parity_oe, w | f);
			if (w | f) begin
				chk(sec_ad_hi_o, mst_data_hi);
				chk(sec_upper_cmd_byte_en_o, mst_be_hi);
				chk(sec_upper_parity_o, ^{mst_addr_hi, mst_cmd});
			end
			cyc(2);
			chk(wide_active, w | f);
			if (w | f)
				chk(sec_upper_parity_o, ^{mst_data_hi, mst_be_hi});
			mst_frame_drive = 1'h0;
			mst_data_phase = 1'h0;
			cyc(1);
			sec_frame_n_i = 1'h1;
			mst_own = 1'h0;
			cyc(3);
		end
	endtask
	task t_abort;
		begin
			dly = 3'h0;
			mst_own = 1'h1;
			mst_frame_drive = 1'h1;
			cyc(1);
			sec_frame_n_i = 1'h0;
			cyc(5);
			chk(master_abort, 1'h0);
			cyc(1);
			chk(master_abort, 1'h1);
			mst_frame_drive = 1'h0;
			cyc(1);
			sec_frame_n_i = 1'h1;
			mst_own = 1'h0;
			cyc(2);
		end
	endtask
	task t_target(input b);
		begin
			bad = b;
			ini_req = 1'h1;
			cyc(1);
			sec_frame_n_i = 1'h0;
			cyc(1);
			tgt_devsel_drive = 1'h1;
			chk(sec_wide_ack_n_o, 1'h1);
			cyc(1);
			chk(sec_wide_ack_n_o, 1'h0);
			tgt_data_phase = 1'h1;
			tgt_xfer = 1'h1;
			drv = 1'h1;
			cyc(1);
			tgt_xfer = 1'h0;
			drv = 1'h0;
			chk(rx_valid, 1'h1);
			chk(rx_data_hi, wdata);
			chk(rx_be_hi, 4'h0);
			// Parity error is a one-cycle pulse one edge after capture
			cyc(1);
			chk(rx_par_err, b);
			cyc(1);
			chk(rx_par_err, 1'h0);
			tgt_data_phase = 1'h0;
			tgt_devsel_drive = 1'h0;
			sec_frame_n_i = 1'h1;
			ini_req = 1'h0;
			cyc(1);
			chk({sec_wide_ack_n_o, sec_wide_ack_n_oe}, 2'h3);
			cyc(1);
			chk(sec_wide_ack_n_oe, 1'h0);
			cyc(2);
		end
	endtask

	initial begin
		t_reset;
		t_master(1'h1, 1'h0);
		t_master(1'h0, 1'h1);
		t_master(1'h0, 1'h0);
		t_abort;
		t_target(1'h0);
		t_target(1'h1);
		end_sim;
	end
endmodule
